// *** rtl/apd_decoder.sv ***
`timescale 1ns/1ps
`include "apd_map.svh"


module apd_decoder (
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  input  wire logic            instr_valid,        // word present
  input  wire logic [15:0]     instr_word,         // program word
  input  wire logic [4:0]      shift_count_reg,    // dynamic shift source
  input  wire logic [8:0]      page_pointer,       // direct page
  input  wire logic [15:0]     indirect_addr,      // current pointer value
  input  wire logic [9:0]      cond_word,          // tp, state, mask
  input  wire logic [3:0]      sum_flags,          // z, neg, ovf, carry
  input  wire logic            branch_input_pin,   // pin level
  input  wire logic            test_control_flag,  // test/control flag
  output logic                 dec_valid_q,        // decode result pulse
  output apd_pkg::apd_op_e     op_q,               // operation
  output logic [1:0]           words_q,            // instruction length
  output logic [2:0]           cycles_q,           // cycles incl. periph
  output logic [4:0]           shift_q,            // shift amount
  output logic                 dyn_shift_q,        // shift was dynamic
  output logic                 unsigned_q,         // data zero-extended
  output logic [15:0]          imm_q,              // short or long imm
  output logic                 addr_mode_q,        // indirect when high
  output logic [6:0]           addr_q,             // direct offset
  output logic [2:0]           ptr_sel_q,          // pointer register
  output logic                 periph_q,           // peripheral access
  output logic                 not_mine_q,         // other group's word
  output logic                 cond_met_q          // condition result
);
  import apd_pkg::*;

  // ============================================================
  // decode of one first word
  function automatic apd_dec_s decode(input logic [15:0] w);
    apd_dec_s d;
    d           = '0;
    d.op        = OP_NONE;
    d.words     = `APD_ONE_WORD;
    d.cycles    = `APD_ONE_CYCLE;
    d.shift     = {1'b0, w[`APD_SHIFT4_MSB:`APD_SHIFT4_LSB]};
    // the BF long-immediate forms keep their shift in the low nibble
    if (w[15:8] == 8'hBF) d.shift = {1'b0, w[3:0]};
    casez (w)
      16'h1???: begin d.op = OP_LOAD_SH; d.mem_ref = 1'b1; end
      16'h2???: begin d.op = OP_ADD_SH;  d.mem_ref = 1'b1; end
      16'h3???: begin d.op = OP_SUB_SH;  d.mem_ref = 1'b1; end
      16'hB8??: d.op = OP_ADD_SHORT;
      16'hBA??: d.op = OP_SUB_SHORT;
      16'b1001_1???_????_????: begin
        d.op      = OP_STORE_HI;
        d.mem_ref = 1'b1;
        d.shift   = {2'h0, w[`APD_SHIFT3_MSB:`APD_SHIFT4_LSB]};
      end
      16'b1001_0???_????_????: begin
        d.op      = OP_STORE_LO;
        d.mem_ref = 1'b1;
        d.shift   = {2'h0, w[`APD_SHIFT3_MSB:`APD_SHIFT4_LSB]};
      end
      16'hBE00: d.op = OP_MAGNITUDE;
      16'hBE01: d.op = OP_COMPLEMENT;
      16'hBE02: d.op = OP_NEGATE;
      16'hBE09: d.op = OP_SHL1;
      16'hBE0A: d.op = OP_SHR1;
      16'hBE0C: d.op = OP_ROL1;
      16'hBE0D: d.op = OP_ROR1;
      16'hBE10: d.op = OP_B_ADD;
      16'hBE11: d.op = OP_B_ADDC;
      16'hBE12: d.op = OP_B_AND;
      16'hBE13: d.op = OP_B_OR;
      16'hBE18: d.op = OP_B_SUB;
      16'hBE19: d.op = OP_B_SUBB;
      16'hBE1A: d.op = OP_B_XOR;
      16'hBE1B: d.op = OP_KEEP_MAX;
      16'hBE1C: d.op = OP_KEEP_MIN;
      16'hBE1D: d.op = OP_SWAP;
      16'hBE1F: d.op = OP_LOAD_FROM_B;
      16'hBE1E: d.op = OP_STORE_TO_B;
      16'h6B??: begin d.op = OP_LOAD_DYN; d.mem_ref = 1'b1; end
      16'h63??: begin d.op = OP_ADD_DYN;  d.mem_ref = 1'b1; end
      16'h67??: begin d.op = OP_SUB_DYN;  d.mem_ref = 1'b1; end
      16'hBE5A: d.op = OP_SHIFT16_COND;
      16'hBE5B: d.op = OP_SHIFT_LOW_DYN;
      16'hBFB?: d.op = OP_AND_LONG;
      16'hBFC?: d.op = OP_OR_LONG;
      16'hBFD?: d.op = OP_XOR_LONG;
      16'hBE81: d.op = OP_AND_LONG;
      16'hBE82: d.op = OP_OR_LONG;
      16'hBE83: d.op = OP_XOR_LONG;
      16'hBF9?: d.op = OP_ADD_LONG;
      16'hBF8?: d.op = OP_LOAD_LONG;
      16'hBFA?: d.op = OP_SUB_LONG;
      16'h08??: begin
        d.op = OP_LOAD_LOW_MAPPED; d.mem_ref = 1'b1; d.mapped = 1'b1;
      end
      16'h88??: begin
        d.op = OP_STORE_LOW_MAPPED; d.mem_ref = 1'b1; d.mapped = 1'b1;
      end
      16'hBE59: d.op = OP_CLEAR_SUM_PROD;
      16'h68??: begin d.op = OP_CLEAR_LOAD_RND; d.mem_ref = 1'b1; end
      16'h62??: begin d.op = OP_ADD_UNSIGNED; d.mem_ref = 1'b1; end
      16'h66??: begin d.op = OP_SUB_UNSIGNED; d.mem_ref = 1'b1; end
      16'b0000_0???_????_????: begin
        d.op = OP_PTR_LOAD_DATA; d.mem_ref = 1'b1;
      end
      16'b1011_0???_????_????: d.op = OP_PTR_LOAD_SHORT;
      16'b1011_1111_0000_1???: d.op = OP_PTR_LOAD_LONG;
      16'hBD??: begin d.op = OP_PAGE_LOAD_IMM; end
      16'h0D??: begin d.op = OP_PAGE_LOAD_DATA; d.mem_ref = 1'b1; end
      16'h78??: d.op = OP_PTR_ADD_SHORT;
      16'h7C??: d.op = OP_PTR_SUB_SHORT;
      default:  d.not_mine = 1'b1;
    endcase
    // the shift-of-sixteen logic forms carry no shift field
    if (w[15:4] == 12'hBE8)
      d.shift = `APD_SHIFT_SIXTEEN;
    // long-immediate forms: second word holds the immediate
    case (d.op)
      OP_AND_LONG, OP_OR_LONG, OP_XOR_LONG, OP_ADD_LONG, OP_LOAD_LONG,
      OP_SUB_LONG, OP_PTR_LOAD_LONG: begin
        d.words  = `APD_TWO_WORDS;
        d.cycles = `APD_TWO_CYCLES;
      end
      OP_PAGE_LOAD_IMM, OP_PAGE_LOAD_DATA:
        d.cycles = `APD_TWO_CYCLES;
      default: ;
    endcase
    return d;
  endfunction

  // ============================================================
  // state and captured first word
  apd_state_e state_q;    // sequencing state
  apd_dec_s   dec_w;      // decode of the incoming word
  apd_dec_s   held_q;     // decode held while waiting for immediate
  logic [15:0] first_q;   // first word held across the immediate
  logic [15:0] eff_addr_w;// effective data address of first word
  logic [15:0] held_addr_q;// address kept with a held first word
  logic       take_first_w; // first word accepted this cycle
  logic       take_imm_w;   // immediate word accepted this cycle
  logic       is_periph_w;  // operand in peripheral window

  assign dec_w        = decode(instr_word);
  assign take_first_w = instr_valid && (state_q == S_IDLE);
  assign take_imm_w   = instr_valid && (state_q == S_IMM);

  // ============================================================
  // effective address: direct-mode mapped forms stay on page zero
  always_comb begin
    if (instr_word[`APD_ADDR_MODE_BIT])
      eff_addr_w = indirect_addr;
    else if (dec_w.mapped)
      eff_addr_w = {9'h000, instr_word[`APD_ADDR_MSB:0]};
    else
      eff_addr_w = {page_pointer, instr_word[`APD_ADDR_MSB:0]};
  end

  // held first words never touch memory, so only the live word counts
  assign is_periph_w = dec_w.mem_ref &&
                       (eff_addr_w >= `APD_PERIPH_LO) &&
                       (eff_addr_w <= `APD_PERIPH_HI);

  // ============================================================
  // sequencing: a two-word form waits for its immediate
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (take_first_w && dec_w.words == `APD_TWO_WORDS)
            state_q <= S_IMM;
        end
        S_IMM: begin
          if (take_imm_w)
            state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ============================================================
  // hold the first word of a two-word form
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      held_q      <= '0;
      first_q     <= `APD_RST_WORD;
      held_addr_q <= `APD_RST_WORD;
    end else if (take_first_w) begin
      held_q      <= dec_w;
      first_q     <= instr_word;
      held_addr_q <= eff_addr_w;
    end
  end

  // ============================================================
  // result pulse: one cycle after the last word is taken
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      dec_valid_q <= 1'b0;
    else
      dec_valid_q <= (take_first_w && dec_w.words == `APD_ONE_WORD) ||
                     take_imm_w;
  end

  // ============================================================
  // decoded fields of a one-word form or of a completed two-word form
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q        <= OP_NONE;
      words_q     <= `APD_ONE_WORD;
      cycles_q    <= `APD_ONE_CYCLE;
      shift_q     <= 5'h00;
      dyn_shift_q <= 1'b0;
      unsigned_q  <= 1'b0;
      imm_q       <= `APD_RST_WORD;
      addr_mode_q <= 1'b0;
      addr_q      <= 7'h00;
      ptr_sel_q   <= 3'h0;
      periph_q    <= 1'b0;
      not_mine_q  <= 1'b0;
    end else if (take_first_w && dec_w.words == `APD_ONE_WORD) begin
      op_q        <= dec_w.op;
      words_q     <= dec_w.words;
      // wait states for external memory are added elsewhere
      cycles_q    <= dec_w.cycles + (is_periph_w ? `APD_PERIPH_EXTRA
                                                 : 3'h0);
      dyn_shift_q <= 1'b0;
      shift_q     <= dec_w.shift;
      case (dec_w.op)
        OP_LOAD_DYN, OP_ADD_DYN, OP_SUB_DYN, OP_SHIFT_LOW_DYN: begin
          shift_q     <= {1'b0, shift_count_reg[3:0]};
          dyn_shift_q <= 1'b1;
        end
        OP_SHIFT16_COND: begin
          // shift only while bit 4 of the count register is clear
          shift_q     <= shift_count_reg[4] ? 5'h00
                                            : `APD_SHIFT_SIXTEEN;
          dyn_shift_q <= 1'b1;
        end
        default: ;
      endcase
      unsigned_q  <= (dec_w.op == OP_ADD_UNSIGNED) ||
                     (dec_w.op == OP_SUB_UNSIGNED);
      imm_q       <= {8'h00, instr_word[`APD_IMM8_MSB:0]};
      addr_mode_q <= instr_word[`APD_ADDR_MODE_BIT];
      addr_q      <= instr_word[`APD_ADDR_MSB:0];
      // three bits can only name pointers 0 to 7
      ptr_sel_q   <= instr_word[`APD_PTR_SEL_MSB:`APD_PTR_SEL_LSB];
      periph_q    <= is_periph_w;
      not_mine_q  <= dec_w.not_mine;
    end else if (take_imm_w) begin
      op_q        <= held_q.op;
      words_q     <= held_q.words;
      cycles_q    <= held_q.cycles;
      shift_q     <= held_q.shift;
      dyn_shift_q <= 1'b0;
      unsigned_q  <= 1'b0;
      imm_q       <= instr_word;
      addr_mode_q <= 1'b0;
      addr_q      <= held_addr_q[`APD_ADDR_MSB:0];
      ptr_sel_q   <= first_q[2:0];
      periph_q    <= 1'b0;
      not_mine_q  <= 1'b0;
    end
  end

  // ============================================================
  // condition evaluation for conditional instructions
  apd_cond_if cond_bus ();
  assign cond_bus.cond_word         = cond_word;
  assign cond_bus.flags             = sum_flags;
  assign cond_bus.branch_input_pin  = branch_input_pin;
  assign cond_bus.test_control_flag = test_control_flag;

  apd_cond_eval u_cond (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .cif     (cond_bus)
  );

  // registered so the result lines up with the decode pulse
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      cond_met_q <= 1'b0;
    else
      cond_met_q <= cond_bus.cond_met;
  end

  // ============================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_load_sh;
    take_first_w && instr_word[15:12] == 4'h1 |=>
      dec_valid_q && op_q == OP_LOAD_SH &&
      shift_q == {1'b0, $past(instr_word[11:8])};
  endproperty
  a_load_sh: assert property (p_load_sh)
    else $error("shifted load decoded wrongly");

  property p_short_imm;
    take_first_w && instr_word[15:8] == 8'hB8 |=>
      op_q == OP_ADD_SHORT && imm_q[7:0] == $past(instr_word[7:0]);
  endproperty
  a_short_imm: assert property (p_short_imm)
    else $error("short immediate not passed");

  property p_dyn;
    take_first_w && instr_word[15:8] == 8'h6B |=>
      dyn_shift_q && shift_q[3:0] == $past(shift_count_reg[3:0]);
  endproperty
  a_dyn: assert property (p_dyn)
    else $error("dynamic shift not from count register");

  property p_sixteen;
    take_first_w && instr_word == 16'hBE5A && !shift_count_reg[4] |=>
      shift_q == 5'h10;
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("conditional sixteen shift wrong");

  // the gap before the immediate is unbounded, so the two halves of the
  // form are checked separately rather than as one long sequence
  property p_two_word;
    take_first_w && instr_word[15:4] == 12'hBF9 |=>
      !dec_valid_q && state_q == S_IMM;
  endproperty
  a_two_word: assert property (p_two_word)
    else $error("long immediate form mis-sequenced");

  property p_long_imm;
    take_imm_w && held_q.op == OP_ADD_LONG |=> dec_valid_q &&
      op_q == OP_ADD_LONG && cycles_q == 3'h2 && imm_q == $past(instr_word);
  endproperty
  a_long_imm: assert property (p_long_imm)
    else $error("long immediate not delivered");

  property p_page;
    take_first_w && instr_word[15:8] == 8'hBD |=> cycles_q == 3'h2;
  endproperty
  a_page: assert property (p_page)
    else $error("page pointer load not two cycles");

  property p_periph;
    take_first_w && dec_w.words == 2'h1 && is_periph_w |=>
      periph_q && cycles_q == $past(dec_w.cycles) + 3'h1;
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral access missing extra cycle");

  property p_foreign;
    take_first_w && instr_word == 16'hFFFF |=> not_mine_q && dec_valid_q;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign encoding not flagged");

  property p_unsigned;
    take_first_w && instr_word[15:8] == 8'h66 |=>
      unsigned_q && op_q == OP_SUB_UNSIGNED;
  endproperty
  a_unsigned: assert property (p_unsigned)
    else $error("sign suppression not flagged");

  c_two_word: cover property (take_imm_w ##1 dec_valid_q);
  c_periph:   cover property (dec_valid_q && periph_q);
  c_mapped:   cover property (dec_valid_q && op_q == OP_LOAD_LOW_MAPPED);
endmodule // apd_decoder

// *** rtl/apd_map.svh ***
`ifndef APD_MAP_SVH
`define APD_MAP_SVH

// ============================================================
// field positions inside an instruction word
`define APD_ADDR_MODE_BIT   7
`define APD_ADDR_MSB        6
`define APD_SHIFT4_MSB      11
`define APD_SHIFT4_LSB      8
`define APD_SHIFT3_MSB      10
`define APD_PTR_SEL_MSB     10
`define APD_PTR_SEL_LSB     8
`define APD_IMM8_MSB        7

// ============================================================
// condition word layout: pin/flag code above two 4-bit fields
`define APD_COND_MASK_MSB   3
`define APD_COND_STATE_MSB  7
`define APD_COND_STATE_LSB  4
`define APD_COND_TP_MSB     9
`define APD_COND_TP_LSB     8

// ============================================================
// word and cycle counts
`define APD_ONE_WORD        2'h1
`define APD_TWO_WORDS       2'h2
`define APD_ONE_CYCLE       3'h1
`define APD_TWO_CYCLES      3'h2
`define APD_PERIPH_EXTRA    3'h1

// ============================================================
// shift figures and the peripheral window in data memory
`define APD_SHIFT_SIXTEEN   5'h10
`define APD_PERIPH_LO       16'h0020
`define APD_PERIPH_HI       16'h004F

// ============================================================
// reset values
`define APD_RST_WORD        16'h0000

`endif

// *** rtl/apd_pkg.sv ***
package apd_pkg;

  // decoded operation
  typedef enum logic [5:0] {
    OP_NONE, OP_LOAD_SH, OP_ADD_SH, OP_SUB_SH, OP_ADD_SHORT, OP_SUB_SHORT,
    OP_STORE_HI, OP_STORE_LO, OP_MAGNITUDE, OP_COMPLEMENT, OP_NEGATE,
    OP_SHL1, OP_SHR1, OP_ROL1, OP_ROR1, OP_B_ADD, OP_B_ADDC, OP_B_AND,
    OP_B_OR, OP_B_SUB, OP_B_SUBB, OP_B_XOR, OP_KEEP_MAX, OP_KEEP_MIN,
    OP_SWAP, OP_LOAD_FROM_B, OP_STORE_TO_B, OP_LOAD_DYN, OP_ADD_DYN,
    OP_SUB_DYN, OP_SHIFT16_COND, OP_SHIFT_LOW_DYN, OP_AND_LONG, OP_OR_LONG,
    OP_XOR_LONG, OP_ADD_LONG, OP_LOAD_LONG, OP_SUB_LONG, OP_LOAD_LOW_MAPPED,
    OP_STORE_LOW_MAPPED, OP_CLEAR_SUM_PROD, OP_CLEAR_LOAD_RND,
    OP_ADD_UNSIGNED, OP_SUB_UNSIGNED, OP_PTR_LOAD_DATA, OP_PTR_LOAD_SHORT,
    OP_PTR_LOAD_LONG, OP_PAGE_LOAD_IMM, OP_PAGE_LOAD_DATA, OP_PTR_ADD_SHORT,
    OP_PTR_SUB_SHORT
  } apd_op_e;

  // result of decoding one first word
  typedef struct packed {
    apd_op_e     op;        // operation
    logic [1:0]  words;     // instruction length
    logic [2:0]  cycles;    // base cycle count, internal memory
    logic [4:0]  shift;     // static shift amount
    logic        dyn_shift; // shift taken from shift_count_reg
    logic        mem_ref;   // touches data memory
    logic        mapped;    // page-zero mapped register access
    logic        not_mine;  // belongs to another decoder group
  } apd_dec_s;

  // decoder sequencing
  typedef enum logic [0:0] {S_IDLE, S_IMM} apd_state_e;

endpackage

// *** rtl/apd_cond_if.sv ***
`timescale 1ns/1ps
// carries a condition word and the flags it is tested against
interface apd_cond_if;
  logic [9:0] cond_word;          // pin/flag code, state, mask
  logic [3:0] flags;              // zero, negative, overflow, carry
  logic       branch_input_pin;   // pin level
  logic       test_control_flag;  // test/control flag
  logic       cond_met;           // evaluated result
  modport dec  (output cond_word, flags, branch_input_pin,
                test_control_flag, input cond_met);
  modport eval (input cond_word, flags, branch_input_pin,
                test_control_flag, output cond_met);
endinterface

// *** rtl/apd_cond_eval.sv ***
`timescale 1ns/1ps
`include "apd_map.svh"

// ============================================================
// condition evaluator for conditional instructions
module apd_cond_eval (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  apd_cond_if.eval  cif
);
  import apd_pkg::*;

  logic [3:0] mask_w;   // which conditions are tested
  logic [3:0] state_w;  // required state of each
  logic [3:0] hit_w;    // per-condition agreement
  logic [1:0] tp_w;     // pin or flag code
  logic       tp_ok_w;  // pin/flag part satisfied

  // ============================================================
  // mask and state fields
  always_comb begin
    mask_w  = cif.cond_word[`APD_COND_MASK_MSB:0];
    state_w = cif.cond_word[`APD_COND_STATE_MSB:`APD_COND_STATE_LSB];
    // flag order is zero, negative, overflow, carry from bit 3 down
    hit_w   = ~(cif.flags ^ state_w);
    tp_w    = cif.cond_word[`APD_COND_TP_MSB:`APD_COND_TP_LSB];
  end

  // ============================================================
  // pin/flag code: the code-to-test mapping here is a chosen one
  always_comb begin
    case (tp_w)
      2'h0:    tp_ok_w = ~cif.branch_input_pin;
      2'h1:    tp_ok_w = cif.test_control_flag;
      2'h2:    tp_ok_w = ~cif.test_control_flag;
      default: tp_ok_w = 1'b1;
    endcase
  end

  // an empty mask leaves only the pin/flag test in force
  assign cif.cond_met = tp_ok_w & ((mask_w == 4'h0) | (|(mask_w & hit_w)));

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_mask_gates;
    (tp_w == 2'h3) && (mask_w != 4'h0) && ((mask_w & hit_w) == 4'h0)
      |-> !cif.cond_met;
  endproperty
  a_mask_gates: assert property (p_mask_gates)
    else $error("condition met with no tested bit agreeing");

  property p_bio_low;
    (tp_w == 2'h0) && cif.branch_input_pin |-> !cif.cond_met;
  endproperty
  a_bio_low: assert property (p_bio_low)
    else $error("pin test passed with pin high");

  c_met: cover property (cif.cond_met && mask_w != 4'h0);
endmodule // apd_cond_eval

// *** tb/apd_pmem.sv ***
`timescale 1ns/1ps
// ============================================================
// program memory model: returns one word per requested edge
module apd_pmem (
  input  wire logic        sys_clk,
  input  wire logic        fetch,
  input  wire logic [15:0] next_word,
  output logic             instr_valid,
  output logic [15:0]      instr_word
);
  // an idle bus inverts its word on every edge, alternating between the inverse and a copy of the last word;
  // one process owns both outputs so each has a single driver
  initial begin
    instr_valid = 1'b0;
    instr_word  = 16'h0000;
    forever @(posedge sys_clk) begin
      instr_valid <= fetch;
      instr_word  <= fetch ? next_word : ~instr_word;
    end
  end
endmodule // apd_pmem

// *** tb/apd_decoder_tb.sv ***
`timescale 1ns/1ps
// ============================================================
// bench: words from the memory model, decode results compared
module apd_decoder_tb;
  import apd_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, fetch = 1'b0;
  logic [15:0] next_word = 16'h0000, instr_word, imm_q;
  logic [4:0] shift_count_reg = 5'h00, shift_q, sv = 5'h00;
  logic [8:0] page_pointer = 9'h000, pv = 9'h000;
  logic [15:0] indirect_addr = 16'h0000, iv = 16'h0000;
  logic [9:0] cond_word = 10'h000;
  logic [3:0] sum_flags = 4'h0;
  logic branch_input_pin = 1'b1, test_control_flag = 1'b0, instr_valid;
  logic dec_valid_q, dyn_shift_q, unsigned_q, addr_mode_q, periph_q;
  logic not_mine_q, cond_met_q;
  logic [1:0] words_q;
  logic [2:0] cycles_q, ptr_sel_q;
  logic [6:0] addr_q;
  apd_op_e op_q;
  int err_total = 0, checks = 0, i;
  // low bytes of the 1011 1110 0000/0001 groups, in decode order
  logic [7:0] lb [19] = '{8'h00, 8'h01, 8'h02, 8'h09, 8'h0A, 8'h0C,
    8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h18, 8'h19, 8'h1A, 8'h1B,
    8'h1C, 8'h1D, 8'h1F, 8'h1E};
  always #10 sys_clk = ~sys_clk;
  apd_pmem pm (.*);
  apd_decoder uut (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one instruction; OP_NONE means a word of another group
  task automatic d(input logic [15:0] w, input logic [15:0] im,
    input apd_op_e o, input logic [1:0] wd, input logic [2:0] cy,
    input logic [4:0] sh);
    int n;
    @(posedge sys_clk);
    fetch <= 1'b1;
    next_word <= w;
    shift_count_reg <= sv;
    page_pointer <= pv;
    indirect_addr <= iv;
    if (wd == 2'h2) begin
      @(posedge sys_clk);
      next_word <= im;
    end
    @(posedge sys_clk);
    fetch <= 1'b0;
    for (n = 0; n < 8 && dec_valid_q !== 1'b1; n++) @(negedge sys_clk);
    chk(16'(dec_valid_q), 16'h0001);
    chk(16'(not_mine_q), 16'(o == OP_NONE));
    if (o != OP_NONE) begin
      chk(16'(op_q), 16'(o));
      chk(16'(words_q), 16'(wd));
      chk(16'(cycles_q), 16'(cy));
    end
    if (sh != 5'h1F) chk(16'(shift_q), 16'(sh));
    if (wd == 2'h2) chk(imm_q, im);
  endtask
  // condition inputs settle, result is looked at one cycle later
  task automatic c(input logic [9:0] cw, input logic [3:0] fl,
    input logic pin, input logic tc, input logic e);
    @(posedge sys_clk);
    cond_word <= cw;
    sum_flags <= fl;
    branch_input_pin <= pin;
    test_control_flag <= tc;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(16'(cond_met_q), 16'(e));
  endtask
  task automatic end_of_test();
    $display("err_total=%0d checks=%0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    d(16'h1312, 16'h0000, OP_LOAD_SH, 2'h1, 3'h1, 5'h03);
    chk(16'(addr_q), 16'h0012);
    d(16'h2520, 16'h0000, OP_ADD_SH, 2'h1, 3'h2, 5'h05);
    pv = 9'h001;
    iv = 16'h004F;
    d(16'h2320, 16'h0000, OP_ADD_SH, 2'h1, 3'h1, 5'h03);
    d(16'h3780, 16'h0000, OP_SUB_SH, 2'h1, 3'h2, 5'h07);
    chk(16'({periph_q, addr_mode_q}), 16'h0003);
    d(16'h0825, 16'h0000, OP_LOAD_LOW_MAPPED, 2'h1, 3'h2, 5'h1F);
    d(16'h8805, 16'h0000, OP_STORE_LOW_MAPPED, 2'h1, 3'h1, 5'h1F);
    d(16'hB87F, 16'h0000, OP_ADD_SHORT, 2'h1, 3'h1, 5'h1F);
    chk(imm_q, 16'h007F);
    d(16'hBA80, 16'h0000, OP_SUB_SHORT, 2'h1, 3'h1, 5'h1F);
    d(16'h9D05, 16'h0000, OP_STORE_HI, 2'h1, 3'h1, 5'h05);
    d(16'h9505, 16'h0000, OP_STORE_LO, 2'h1, 3'h1, 5'h05);
    for (i = 0; i < 19; i++) begin
      d({8'hBE, lb[i]}, 16'h0000, apd_op_e'(OP_MAGNITUDE + i), 2'h1,
        3'h1, 5'h1F);
    end
    sv = 5'h17;
    d(16'h6B05, 16'h0000, OP_LOAD_DYN, 2'h1, 3'h1, 5'h07);
    chk(16'(dyn_shift_q), 16'h0001);
    d(16'h6705, 16'h0000, OP_SUB_DYN, 2'h1, 3'h1, 5'h07);
    d(16'hBE5A, 16'h0000, OP_SHIFT16_COND, 2'h1, 3'h1, 5'h00);
    sv = 5'h0B;
    d(16'hBE5A, 16'h0000, OP_SHIFT16_COND, 2'h1, 3'h1, 5'h10);
    d(16'hBE5B, 16'h0000, OP_SHIFT_LOW_DYN, 2'h1, 3'h1, 5'h0B);
    d(16'hBFB3, 16'hA5A5, OP_AND_LONG, 2'h2, 3'h2, 5'h03);
    d(16'hBE83, 16'h5A5A, OP_XOR_LONG, 2'h2, 3'h2, 5'h10);
    d(16'hBF95, 16'h1234, OP_ADD_LONG, 2'h2, 3'h2, 5'h05);
    d(16'hBFAF, 16'hFFFF, OP_SUB_LONG, 2'h2, 3'h2, 5'h0F);
    d(16'hBE59, 16'h0000, OP_CLEAR_SUM_PROD, 2'h1, 3'h1, 5'h1F);
    d(16'h6805, 16'h0000, OP_CLEAR_LOAD_RND, 2'h1, 3'h1, 5'h1F);
    d(16'h6605, 16'h0000, OP_SUB_UNSIGNED, 2'h1, 3'h1, 5'h1F);
    chk(16'(unsigned_q), 16'h0001);
    d(16'h0705, 16'h0000, OP_PTR_LOAD_DATA, 2'h1, 3'h1, 5'h1F);
    chk(16'(ptr_sel_q), 16'h0007);
    d(16'hBF0D, 16'h0042, OP_PTR_LOAD_LONG, 2'h2, 3'h2, 5'h1F);
    chk(16'(ptr_sel_q), 16'h0005);
    d(16'hBD05, 16'h0000, OP_PAGE_LOAD_IMM, 2'h1, 3'h2, 5'h1F);
    d(16'h0D05, 16'h0000, OP_PAGE_LOAD_DATA, 2'h1, 3'h2, 5'h1F);
    d(16'h7C05, 16'h0000, OP_PTR_SUB_SHORT, 2'h1, 3'h1, 5'h1F);
    d(16'hA000, 16'h0000, OP_NONE, 2'h1, 3'h1, 5'h1F);
    d(16'hFFFF, 16'h0000, OP_NONE, 2'h1, 3'h1, 5'h1F);
    c(10'h311, 4'h1, 1'b1, 1'b0, 1'b1);
    c(10'h311, 4'hE, 1'b1, 1'b0, 1'b0);
    c(10'h000, 4'h0, 1'b0, 1'b0, 1'b1);
    c(10'h000, 4'h0, 1'b1, 1'b1, 1'b0);
    c(10'h200, 4'h0, 1'b0, 1'b1, 1'b0);
    c(10'h100, 4'h0, 1'b1, 1'b1, 1'b1);
    end_of_test();
  end
endmodule // apd_decoder_tb
